// ===== rtl/lpc_host.sv
// Functional notes
// - later read after X cycles concatenates/truncates.
// - burst terminate X cycles after read truncates.
// - read completes or terminated before any write.
// - precharge X cycles after read, no auto precharge.
// - wait precharge time after precharge, same bank.
// - never terminate write bursts with burst terminate.
// - host strobe preamble and postamble around writes.
// - first write strobe rise within quarter cycle.
// - write after write concatenates, X cycles later.
// - wait write to read delay before read.
// - read truncating write needs later data masked.
// - precharge after write waits write recovery.
// - precharge truncating write needs later data masked.
`include "lpc_params.svh"

module lpc_host (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cl_three,
  input wire logic req_valid,
  input wire lpc_pkg::lpc_cmd_e req_cmd,
  input wire logic [1:0] req_bank,
  input wire logic [9:0] req_col,
  input wire logic req_ap,
  input wire logic [1:0] req_pairs,
  output logic req_ready,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] wr_byte_mask,
  output logic wr_take,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic device_clk,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bank_select,
  output logic bank_select_high,
  output logic [9:0] column,
  output logic auto_precharge_bit,
  input wire logic [15:0] data_lines_in,
  output logic [15:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic data_strobe_in,
  output logic data_strobe_out,
  output logic data_strobe_oe,
  output logic [1:0] write_mask
);
  import lpc_pkg::*;

  lpc_state_s s_q;
  lpc_state_s s_d;
  logic [2:0] cl;
  logic [2:0] pe;
  logic [4:0] apx;
  logic [4:0] gap_req;
  logic take;
  logic bst_due;
  logic [15:0] rd_load;
  logic [7:0] wd_load;
  logic [7:0] wm_load;
  logic [7:0] oe_load;

  // ****************************************
  // Next-state logic
  // ****************************************
  // Everything advances on clk; device_clk is clk divided by two, so
  // one device cycle is a slot of two clk edges and commands change
  // only at slot edges, while device_clk falls.
  always_comb begin
    s_d = s_q;
    cl = cl_three ? 3'h3 : 3'h2;
    pe = (req_pairs == 2'h0 || 3'(req_pairs) > 3'(`LPC_BL / 2))
      ? 3'(`LPC_BL / 2) : {1'b0, req_pairs};
    apx = req_ap ? 5'(`LPC_TRP_SLOTS) : 5'h00;
    take = s_q.ph && s_q.ready && req_valid;
    bst_due = s_q.ph && (s_q.bst_cnt == 3'h1);
    rd_load = ((16'h0001 << {pe, 1'b0}) - 16'h0001)
      << (5'(`LPC_RD_SKEW) + {1'b0, cl, 1'b0});
    wd_load = ((8'h01 << {pe, 1'b0}) - 8'h01) << `LPC_WR_FIRST;
    wm_load = (((8'h01 << `LPC_BL) - 8'h01) << `LPC_WR_FIRST) & ~wd_load;
    oe_load = ((8'h01 << (`LPC_BL + 2)) - 8'h01) << (`LPC_WR_FIRST - 1);
    case (req_cmd)
      LPC_RD: gap_req = s_q.gap_rd;
      LPC_WR: gap_req = s_q.gap_wr;
      default: gap_req = s_q.gap_pre;
    endcase

    // Divider and pin synchronisers; only stage two is read further on.
    s_d.ph = !s_q.ph;
    s_d.sy1_dq = data_lines_in;
    s_d.sy2_dq = s_q.sy1_dq;
    s_d.sy1_dqs = data_strobe_in;
    s_d.sy2_dqs = s_q.sy1_dqs;

    s_d.rd_valid = s_q.rd_sched[1];
    s_d.rd_data = s_q.sy2_dq;
    s_d.rd_sched = s_q.rd_sched >> 1;
    s_d.wd_sched = s_q.wd_sched >> 1;
    s_d.wm_sched = s_q.wm_sched >> 1;
    s_d.oe_sched = s_q.oe_sched >> 1;

    s_d.dq_oe = s_q.oe_sched[1];
    s_d.dqs_oe = s_q.oe_sched[1];
    s_d.dqs_o = (s_q.wd_sched[1] || s_q.wm_sched[1]) && !s_q.ph;
    if (s_q.wd_sched[1]) begin
      s_d.dq_o = wr_data;
      s_d.wm = wr_byte_mask;
    end else begin
      s_d.wm = 2'h3;
    end

    // Ready is offered in the cycle before a slot edge, for one cycle.
    s_d.ready = !s_q.ph && req_valid && req_cmd != LPC_BST
      && gap_req <= 5'h01 && s_q.bst_cnt != 3'h1;
    s_d.issue = 1'b0;
    s_d.since = (s_q.since == 8'hFF) ? s_q.since : s_q.since + 8'h01;

    if (s_q.ph) begin
      s_d.cs_n = 1'b0;
      s_d.rcw = `LPC_OP_NOP;
      s_d.gap_rd = (s_q.gap_rd == 5'h00) ? 5'h00 : s_q.gap_rd - 5'h01;
      s_d.gap_wr = (s_q.gap_wr == 5'h00) ? 5'h00 : s_q.gap_wr - 5'h01;
      s_d.gap_pre = (s_q.gap_pre == 5'h00) ? 5'h00 : s_q.gap_pre - 5'h01;
      s_d.bst_cnt = (s_q.bst_cnt == 3'h0) ? 3'h0 : s_q.bst_cnt - 3'h1;
      if (bst_due || take) begin
        s_d.issue = 1'b1;
        s_d.prev_kind = s_q.kind;
        s_d.prev_p = s_q.p;
        s_d.gap_seen = (s_q.since == 8'hFF) ? s_q.since : s_q.since + 8'h01;
        s_d.since = 8'h00;
      end
      if (bst_due) begin
        s_d.rcw = `LPC_OP_BST;
        s_d.kind = LPC_BST;
        s_d.p = 3'h0;
        s_d.gap_rd = 5'h01;
        s_d.gap_pre = 5'h01;
        s_d.gap_wr = 5'(cl) + 5'h01;
      end else if (take) begin
        s_d.bank = req_bank;
        s_d.col = req_col;
        s_d.ap = (req_cmd == LPC_PRE) ? 1'b0 : req_ap;
        s_d.kind = req_cmd;
        s_d.p = pe;
        case (req_cmd)
          LPC_RD: begin
            s_d.rcw = `LPC_OP_RD;
            s_d.rd_sched = s_d.rd_sched | rd_load;
            s_d.gap_rd = 5'(pe) + apx;
            s_d.gap_pre = 5'(pe) + apx;
            s_d.gap_wr = 5'(cl) + 5'(pe) + 5'h01 + apx;
            if (!req_ap && pe < 3'(`LPC_BL / 2)) begin
              s_d.bst_cnt = pe;
            end
          end
          LPC_WR: begin
            s_d.rcw = `LPC_OP_WR;
            s_d.wd_sched = s_d.wd_sched | wd_load;
            s_d.wm_sched = (s_d.wm_sched & ~wd_load) | wm_load;
            s_d.oe_sched = s_d.oe_sched | oe_load;
            s_d.gap_wr = 5'(pe) + apx;
            s_d.gap_rd = 5'h01 + 5'(pe) + 5'(`LPC_TWTR_CK) + apx;
            s_d.gap_pre = 5'h01 + 5'(pe) + 5'(`LPC_WRITE_RECOVERY_SLOTS) + apx;
          end
          default: begin
            s_d.rcw = `LPC_OP_PRE;
            s_d.gap_rd = 5'(`LPC_TRP_SLOTS);
            s_d.gap_wr = 5'(`LPC_TRP_SLOTS);
            s_d.gap_pre = 5'(`LPC_TRP_SLOTS);
          end
        endcase
      end
    end
    // The user sees take in the cycle whose closing edge consumes data.
    s_d.take = s_d.wd_sched[1];
  end

  // ****************************************
  // State register
  // ****************************************
  // Synchronous reset leaves the device deselected and the bus released.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.cs_n <= 1'b1;
      s_q.rcw <= `LPC_OP_NOP;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a field of the state register.
  assign req_ready = s_q.ready;
  assign wr_take = s_q.take;
  assign rd_valid = s_q.rd_valid;
  assign rd_data = s_q.rd_data;
  assign device_clk = s_q.ph;
  assign cs_n = s_q.cs_n;
  assign ras_n = s_q.rcw[2];
  assign cas_n = s_q.rcw[1];
  assign we_n = s_q.rcw[0];
  assign bank_select = s_q.bank[0];
  assign bank_select_high = s_q.bank[1];
  assign column = s_q.col;
  assign auto_precharge_bit = s_q.ap;
  assign data_lines_out = s_q.dq_o;
  assign data_lines_oe = s_q.dq_oe;
  assign data_strobe_out = s_q.dqs_o;
  assign data_strobe_oe = s_q.dqs_oe;
  assign write_mask = s_q.wm;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_bst_after_read;
    s_q.issue && s_q.kind == LPC_RD && s_q.p == 3'h1 && !s_q.ap
      |-> ##2 (s_q.issue && s_q.kind == LPC_BST);
  endproperty
  a_bst_after_read: assert property (p_bst_after_read)
    else $error("burst terminate not one slot after short read");

  property p_no_write_over_read;
    s_q.issue && s_q.kind == LPC_WR |-> (s_q.rd_sched >> 6) == 16'h0000;
  endproperty
  a_no_write_over_read: assert property (p_no_write_over_read)
    else $error("write issued while read data still due");

  property p_read_follow;
    s_q.issue && s_q.prev_kind == LPC_RD && s_q.kind != LPC_WR
      |-> s_q.gap_seen >= 8'({s_q.prev_p, 1'b0});
  endproperty
  a_read_follow: assert property (p_read_follow)
    else $error("command after read too early");

  property p_pre_wait;
    s_q.issue && s_q.prev_kind == LPC_PRE
      |-> s_q.gap_seen >= 8'(2 * `LPC_TRP_SLOTS);
  endproperty
  a_pre_wait: assert property (p_pre_wait)
    else $error("command inside precharge time");

  property p_bst_read_only;
    s_q.issue && s_q.kind == LPC_BST |-> s_q.prev_kind == LPC_RD;
  endproperty
  a_bst_read_only: assert property (p_bst_read_only)
    else $error("burst terminate not after a read");

  property p_wr_strobe;
    s_q.issue && s_q.kind == LPC_WR
      |-> ##2 (s_q.dqs_oe && !s_q.dqs_o) ##1 (s_q.dqs_oe && s_q.dqs_o);
  endproperty
  a_wr_strobe: assert property (p_wr_strobe)
    else $error("write strobe preamble or first rise misplaced");

  property p_wtr;
    s_q.issue && s_q.kind == LPC_RD && s_q.prev_kind == LPC_WR
      |-> s_q.gap_seen >= 8'(2 * (1 + s_q.prev_p + `LPC_TWTR_CK));
  endproperty
  a_wtr: assert property (p_wtr)
    else $error("read too soon after write");

  property p_write_recovery;
    s_q.issue && s_q.kind == LPC_PRE && s_q.prev_kind == LPC_WR
      |-> s_q.gap_seen >= 8'(2 * (1 + s_q.prev_p + `LPC_WRITE_RECOVERY_SLOTS));
  endproperty
  a_write_recovery: assert property (p_write_recovery)
    else $error("precharge inside write recovery");

  property p_trunc_mask;
    (s_q.issue && s_q.kind == LPC_WR && s_q.p == 3'h1)
      ##2 !(s_q.issue && s_q.kind == LPC_WR)
      |-> ##3 (s_q.wm == 2'h3) ##1 (s_q.wm == 2'h3);
  endproperty
  a_trunc_mask: assert property (p_trunc_mask)
    else $error("elements past a short write are not masked");

  c_concat_read: cover property (s_q.issue && s_q.kind == LPC_RD
    ##4 (s_q.issue && s_q.kind == LPC_RD));
  c_bst: cover property (s_q.issue && s_q.kind == LPC_BST);
  c_concat_write: cover property (s_q.issue && s_q.kind == LPC_WR
    ##4 (s_q.issue && s_q.kind == LPC_WR));
  c_read_strobe: cover property (s_q.rd_valid && s_q.sy2_dqs);
endmodule // lpc_host

// ===== rtl/lpc_params.svh
`ifndef LPC_PARAMS_SVH
`define LPC_PARAMS_SVH
// ****************************************
// Burst and timing figures
// ****************************************
`define LPC_BL 4
`define LPC_CLK_NS 10
`define LPC_CK_NS (2 * `LPC_CLK_NS)
`define LPC_TRP_NS 18
`define LPC_WRITE_RECOVERY_NS 15
`define LPC_TWTR_CK 2
`define LPC_TRP_SLOTS ((`LPC_TRP_NS + `LPC_CK_NS - 1) / `LPC_CK_NS)
`define LPC_WRITE_RECOVERY_SLOTS ((`LPC_WRITE_RECOVERY_NS + `LPC_CK_NS - 1) / `LPC_CK_NS)
`define LPC_WR_FIRST 3
`define LPC_RD_SKEW 4
// ****************************************
// Command pin codes, order ras_n cas_n we_n
// ****************************************
`define LPC_OP_NOP 3'h7
`define LPC_OP_RD 3'h5
`define LPC_OP_WR 3'h4
`define LPC_OP_PRE 3'h2
`define LPC_OP_BST 3'h6
`endif

// ===== rtl/lpc_pkg.sv
package lpc_pkg;
  // Request kinds; burst terminate is only ever issued internally.
  typedef enum logic [1:0] {LPC_RD, LPC_WR, LPC_PRE, LPC_BST} lpc_cmd_e;

  // Whole state of the host engine, registered as one word.
  typedef struct packed {
    logic ph;
    logic cs_n;
    logic [2:0] rcw;
    logic [1:0] bank;
    logic [9:0] col;
    logic ap;
    logic [15:0] dq_o;
    logic dq_oe;
    logic dqs_o;
    logic dqs_oe;
    logic [1:0] wm;
    logic [15:0] sy1_dq;
    logic [15:0] sy2_dq;
    logic sy1_dqs;
    logic sy2_dqs;
    logic [15:0] rd_sched;
    logic [7:0] wd_sched;
    logic [7:0] wm_sched;
    logic [7:0] oe_sched;
    logic [4:0] gap_rd;
    logic [4:0] gap_wr;
    logic [4:0] gap_pre;
    logic [2:0] bst_cnt;
    logic ready;
    logic take;
    logic rd_valid;
    logic [15:0] rd_data;
    logic issue;
    lpc_cmd_e kind;
    lpc_cmd_e prev_kind;
    logic [2:0] p;
    logic [2:0] prev_p;
    logic [7:0] since;
    logic [7:0] gap_seen;
  } lpc_state_s;
endpackage

// ===== dv/lpc_dev_model.sv
`include "lpc_params.svh"

// ****************************************
// Memory device seen at the command pins
// ****************************************
module lpc_dev_model (
  input wire logic device_clk,
  input wire logic cl_three,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select,
  input wire logic bank_select_high,
  input wire logic [9:0] column,
  input wire logic auto_precharge_bit,
  input wire logic [15:0] data_lines_in,
  input wire logic data_strobe_in,
  input wire logic [1:0] write_mask,
  output logic [15:0] dev_dq,
  output logic dev_dq_oe,
  output logic dev_dqs,
  output logic dev_dqs_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:4095];
  logic [11:0] rd_base, wr_base;
  logic [11:0] ra [0:63];
  logic [11:0] wa [0:63];
  logic rv [0:63];
  logic rp [0:63];
  logic wv [0:63];
  logic [2:0] op;
  logic rd_ap;
  int hc, lat, rs, ws;
  assign op = {ras_n, cas_n, we_n};
  // Memory starts cleared, with no burst pending.
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      ra[i] = 12'h000;
      wa[i] = 12'h000;
      rv[i] = 1'b0;
      rp[i] = 1'b0;
      wv[i] = 1'b0;
    end
    hc = 0;
    lat = 4;
    rs = 0;
    ws = 0;
    rd_ap = 1'b0;
    rd_base = 12'h000;
    wr_base = 12'h000;
    {dev_dq, dev_dq_oe, dev_dqs, dev_dqs_oe} = '0;
  end
  // Commands land on the rising edge; every half cycle is one slot of a ring schedule.
  // Bursts are booked slot by slot, so a later command cuts only what it overlaps.
  always @(device_clk) begin
    hc = hc + 1;
    lat = cl_three ? 6 : 4;
    // Slots already served are freed so the ring can be reused.
    rv[(hc + 63) % 64] = 1'b0;
    wv[(hc + 63) % 64] = 1'b0;
    if (device_clk && !cs_n && op == `LPC_OP_RD) begin
      rd_base = {bank_select_high, bank_select, column};
      rd_ap = auto_precharge_bit;
      for (int i = 0; i < 4; i++) begin
        rv[(hc + lat + i) % 64] = 1'b1;
        rp[(hc + lat + i) % 64] = i[0];
        ra[(hc + lat + i) % 64] = rd_base + 12'(i);
      end
    end
    if (device_clk && !cs_n && op == `LPC_OP_WR) begin
      wr_base = {bank_select_high, bank_select, column};
      for (int i = 0; i < 4; i++) begin
        wv[(hc + 2 + i) % 64] = 1'b1;
        wa[(hc + 2 + i) % 64] = wr_base + 12'(i);
      end
    end
    if (device_clk && !cs_n && !rd_ap && (op == `LPC_OP_BST ||
        (op == `LPC_OP_PRE && {bank_select_high, bank_select} == rd_base[11:10]))) begin
      for (int i = 0; i < 4; i++) rv[(hc + lat + i) % 64] = 1'b0;
    end
    rs = hc % 64;
    dev_dqs_oe = rv[rs] || rv[(hc + 1) % 64] || rv[(hc + 2) % 64];
    dev_dq_oe = rv[rs];
    dev_dqs = dev_dqs_oe ? (rv[rs] && !rp[rs]) : ~dev_dqs;
    dev_dq = dev_dq_oe ? mem[ra[rs]] : ~dev_dq;
  end
  // Elements are taken just after each strobe edge, once they have settled.
  always @(data_strobe_in) begin
    #1;
    ws = hc % 64;
    if (wv[ws]) begin
      if (!write_mask[0]) mem[wa[ws]][7:0] = data_lines_in[7:0];
      if (!write_mask[1]) mem[wa[ws]][15:8] = data_lines_in[15:8];
      wv[ws] = 1'b0;
    end
  end
endmodule // lpc_dev_model

// ===== dv/testbench.sv
`include "lpc_params.svh"

// ****************************************
// Host engine against the device model
// ****************************************
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import lpc_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, cl_three = 1'b0, req_valid = 1'b0, req_ap = 1'b0;
  lpc_cmd_e req_cmd = LPC_RD;
  logic [1:0] req_bank = 2'h0, req_pairs = 2'h0, wr_byte_mask = 2'h0, write_mask;
  logic [9:0] req_col = 10'h000, column;
  logic [15:0] wr_data = 16'h0000, rd_data, data_lines_out, dev_dq, data_lines_in;
  logic req_ready, wr_take, rd_valid, device_clk, cs_n, ras_n, cas_n, we_n, bank_select;
  logic bank_select_high, auto_precharge_bit, data_lines_oe, data_strobe_out, data_strobe_oe;
  logic dev_dq_oe, dev_dqs, dev_dqs_oe, data_strobe_in;
  logic [15:0] shadow [0:4095];
  logic [17:0] wq [$];
  logic [15:0] rq [$], eq [$];
  int error_cnt = 0;
  int checks_done = 0;
  // No pull on the lines: a released line shows the model's changing pattern.
  assign data_lines_in = data_lines_oe ? data_lines_out : dev_dq;
  assign data_strobe_in = data_strobe_oe ? data_strobe_out : dev_dqs;
  always #5 clk = ~clk;
  lpc_host dut_u (.clk, .resetn, .cl_three, .req_valid, .req_cmd, .req_bank, .req_col, .req_ap,
    .req_pairs, .req_ready, .wr_data, .wr_byte_mask, .wr_take, .rd_valid, .rd_data, .device_clk,
    .cs_n, .ras_n, .cas_n, .we_n, .bank_select, .bank_select_high, .column, .auto_precharge_bit,
    .data_lines_in, .data_lines_out, .data_lines_oe, .data_strobe_in, .data_strobe_out,
    .data_strobe_oe, .write_mask);
  lpc_dev_model dev_u (.device_clk, .cl_three, .cs_n, .ras_n, .cas_n, .we_n, .bank_select,
    .bank_select_high, .column, .auto_precharge_bit, .data_lines_in, .data_strobe_in,
    .write_mask, .dev_dq, .dev_dq_oe, .dev_dqs, .dev_dqs_oe);
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timeout();
    error_cnt++;
    $display("[ERR] %0t wait limit reached", $time);
    complete_run();
  endtask
  // Falling edge exchange keeps clear of the host's own updates.
  always @(negedge clk) begin
    if (wr_take === 1'b1 && wq.size() > 0) {wr_byte_mask, wr_data} = wq.pop_front();
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (data_lines_oe === 1'b1 && dev_dq_oe) chk(16'h0001, 16'h0000);
  end
  task automatic issue(input lpc_cmd_e c, input logic [1:0] b, input logic [9:0] col,
      input logic ap, input logic [1:0] p);
    int n;
    logic [2:0] op;
    n = 0;
    op = c == LPC_RD ? `LPC_OP_RD : c == LPC_WR ? `LPC_OP_WR : `LPC_OP_PRE;
    @(negedge clk);
    {req_valid, req_cmd, req_bank, req_col, req_ap, req_pairs} = {1'b1, c, b, col, ap, p};
    while (req_ready !== 1'b1) begin
      n++;
      if (n > 300) timeout();
      @(negedge clk);
    end
    @(negedge clk);
    req_valid = 1'b0;
    chk({13'h0000, ras_n, cas_n, we_n}, {13'h0000, op});
    chk({2'h0, cs_n, auto_precharge_bit, bank_select_high, bank_select,
      c == LPC_PRE ? 10'h000 : column}, {3'h0, ap && c != LPC_PRE, b,
      c == LPC_PRE ? 10'h000 : col});
  endtask
  task automatic wr(input logic [1:0] b, input logic [9:0] col, input logic [1:0] p,
      input logic [15:0] d, input logic [1:0] m, input logic ap);
    logic [11:0] a;
    logic [15:0] e;
    logic [1:0] mi;
    for (int i = 0; i < (p == 2'h1 ? 2 : 4); i++) begin
      a = {b, col + 10'(i)};
      e = d + 16'(i);
      mi = i[0] ? m : 2'h0;
      wq.push_back({mi, e});
      if (!mi[0]) shadow[a][7:0] = e[7:0];
      if (!mi[1]) shadow[a][15:8] = e[15:8];
    end
    issue(LPC_WR, b, col, ap, p);
  endtask
  task automatic rd(input logic [1:0] b, input logic [9:0] col, input logic [1:0] p,
      input logic ap);
    for (int i = 0; i < (p == 2'h1 ? 2 : 4); i++) eq.push_back(shadow[{b, col + 10'(i)}]);
    issue(LPC_RD, b, col, ap, p);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (rq.size() < eq.size()) begin
      n++;
      if (n > 300) timeout();
      @(negedge clk);
    end
    repeat (20) @(negedge clk);
    chk(16'(rq.size()), 16'(eq.size()));
    while (eq.size() > 0 && rq.size() > 0) chk(rq.pop_front(), eq.pop_front());
    chk({15'h0000, data_lines_oe}, 16'h0000);
  endtask
  // Back to back writes, upper bytes masked in the odd elements of one, then concatenated reads.
  task automatic s_wr_rd();
    wr(2'h1, 10'h010, 2'h2, 16'h1200, 2'h0, 1'b0);
    wr(2'h1, 10'h014, 2'h2, 16'h3400, 2'h2, 1'b0);
    rd(2'h1, 10'h010, 2'h2, 1'b0);
    rd(2'h1, 10'h014, 2'h2, 1'b0);
    drain();
  endtask
  // A short write over a full one must leave the tail elements untouched.
  task automatic s_short();
    wr(2'h2, 10'h020, 2'h2, 16'hA000, 2'h1, 1'b0);
    wr(2'h2, 10'h020, 2'h1, 16'hB000, 2'h0, 1'b1);
    rd(2'h2, 10'h020, 2'h0, 1'b0);
    drain();
  endtask
  // Latency three with a terminated short read and an auto precharge read.
  task automatic s_cl3();
    cl_three = 1'b1;
    rd(2'h1, 10'h010, 2'h1, 1'b0);
    rd(2'h2, 10'h020, 2'h2, 1'b0);
    rd(2'h1, 10'h014, 2'h2, 1'b1);
    drain();
  endtask
  // Read closed by precharge, then the same bank again after the wait.
  task automatic s_pre();
    cl_three = 1'b0;
    rd(2'h2, 10'h020, 2'h2, 1'b0);
    issue(LPC_PRE, 2'h2, 10'h000, 1'b0, 2'h0);
    rd(2'h2, 10'h020, 2'h1, 1'b0);
    drain();
  endtask
  // Reset for three cycles, then the scenarios in turn.
  initial begin
    for (int i = 0; i < 4096; i++) shadow[i] = 16'h0000;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    s_wr_rd();
    s_short();
    s_cl3();
    s_pre();
    complete_run();
  end
endmodule // testbench
